// [hw/scrb_pkg.sv]
// Package with the register map, field positions and reset values of the config bank.
package scrb_pkg;

	// ----------------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------------
	localparam logic [7:0] SCRB_PROF_OUTDIV = 8'h10;
	localparam logic [7:0] SCRB_PROF_FBINT = 8'h11;
	localparam logic [7:0] SCRB_PROF_CTRL = 8'h12;
	localparam logic [7:0] SCRB_PROF_FRAC_LO = 8'h13;
	localparam logic [7:0] SCRB_PROF_FRAC_HI = 8'h15;
	localparam logic [7:0] SCRB_MISC_FIRST = 8'h50;
	localparam logic [7:0] SCRB_OSC_MODE = 8'h51;
	localparam logic [7:0] SCRB_VC_GAIN = 8'h52;
	localparam logic [7:0] SCRB_OUT_CFG = 8'h53;
	localparam logic [7:0] SCRB_XO_TRIM1 = 8'h55;
	localparam logic [7:0] SCRB_XO_SLICE = 8'h56;
	localparam logic [7:0] SCRB_XO_OT = 8'h57;
	localparam logic [7:0] SCRB_OTP_TRIG = 8'h60;
	localparam logic [7:0] SCRB_APPLY_TRIG = 8'h62;
	localparam logic [7:0] SCRB_RD_UNMAPPED = 8'h00;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int SCRB_BIT_LARGE = 0;
	localparam int SCRB_BIT_SMALL = 1;
	localparam int SCRB_BIT_FIXED = 2;
	localparam int SCRB_BIT_DBL_DIS = 7;
	localparam int SCRB_BIT_OUTDIV_MSB = 7;
	localparam int SCRB_BIT_FBINT_MSB = 6;
	localparam int SCRB_CP_LSB = 1;
	localparam int SCRB_CP_W = 3;
	localparam int SCRB_DIV_W = 9;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [7:0] SCRB_RST_OUTDIV = 8'h38;
	localparam logic [7:0] SCRB_RST_FBINT = 8'h46;
	localparam logic [7:0] SCRB_RST_CTRL = 8'h09;
	localparam logic [7:0] SCRB_RST_50 = 8'h15;
	localparam logic [7:0] SCRB_RST_51 = 8'hC0;
	localparam logic [7:0] SCRB_RST_52 = 8'h2A;
	localparam logic [7:0] SCRB_RST_53 = 8'h82;
	localparam logic [7:0] SCRB_RST_55 = 8'h94;
	localparam logic [7:0] SCRB_RST_56 = 8'h82;
	localparam logic [7:0] SCRB_RST_57 = 8'h58;
	localparam logic [7:0] SCRB_RST_ZERO = 8'h00;

	// Reserved bytes and their fixed defaults, index for index.
	localparam int SCRB_NRSVD = 33;
	localparam logic [7:0] SCRB_RSVD_ADDR [SCRB_NRSVD] = '{
		8'h63, 8'h70, 8'h71, 8'h80, 8'h81, 8'h82, 8'h83, 8'h90, 8'h91, 8'h92, 8'h93,
		8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E,
		8'h9F, 8'hA0, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hD3, 8'hD6, 8'hD7, 8'hE5};
	localparam logic [7:0] SCRB_RSVD_RST [SCRB_NRSVD] = '{
		8'h00, 8'h0C, 8'h08, 8'h30, 8'h06, 8'h06, 8'h02, 8'h00, 8'h06, 8'h06, 8'h00,
		8'h06, 8'h00, 8'h02, 8'h06, 8'h06, 8'h00, 8'h02, 8'h00, 8'h02, 8'h03, 8'h00,
		8'hC0, 8'h01, 8'h42, 8'h03, 8'h64, 8'h14, 8'h00, 8'h03, 8'h13, 8'h1C, 8'h30};

	// True for every byte address that holds a register.
	function automatic logic scrb_is_mapped(input logic [7:0] addr);
		logic hit;
		hit = (addr >= SCRB_PROF_OUTDIV && addr <= SCRB_PROF_FRAC_HI)
			|| (addr >= SCRB_MISC_FIRST && addr <= SCRB_XO_OT)
			|| addr == SCRB_OTP_TRIG || addr == SCRB_APPLY_TRIG;
		for (int i = 0; i < SCRB_NRSVD; i++)
			hit = hit | (addr == SCRB_RSVD_ADDR[i]);
		return hit;
	endfunction : scrb_is_mapped

	// Reset value of each byte; unmapped bytes stay zero.
	function automatic logic [7:0] scrb_default(input logic [7:0] addr);
		logic [7:0] val;
		val = SCRB_RST_ZERO;
		case (addr)
			SCRB_PROF_OUTDIV: val = SCRB_RST_OUTDIV;
			SCRB_PROF_FBINT: val = SCRB_RST_FBINT;
			SCRB_PROF_CTRL: val = SCRB_RST_CTRL;
			SCRB_MISC_FIRST: val = SCRB_RST_50;
			SCRB_OSC_MODE: val = SCRB_RST_51;
			SCRB_VC_GAIN: val = SCRB_RST_52;
			SCRB_OUT_CFG: val = SCRB_RST_53;
			SCRB_XO_TRIM1: val = SCRB_RST_55;
			SCRB_XO_SLICE: val = SCRB_RST_56;
			SCRB_XO_OT: val = SCRB_RST_57;
			default: val = SCRB_RST_ZERO;
		endcase
		for (int i = 0; i < SCRB_NRSVD; i++)
			if (addr == SCRB_RSVD_ADDR[i])
				val = SCRB_RSVD_RST[i];
		return val;
	endfunction : scrb_default

endpackage : scrb_pkg

// [hw/scrb_rise_detect.sv]
// Zero-to-one edge detector for the trigger bits of the config bank.
`timescale 1ns/1ps
`default_nettype none

module scrb_rise_detect
#(
	parameter int W = 2
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Level in, one-cycle pulse out.
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);

	logic [W-1:0] prev_ff;
	logic [W-1:0] nxt_prev;

	// Remember last cycle's level.
	always_comb
	begin
		nxt_prev = level;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prev_ff <= '0;
		else
			prev_ff <= nxt_prev;
	end

	// A bit held high fires once; it must drop before it can fire again.
	assign rise = level & ~prev_ff;

endmodule : scrb_rise_detect

`default_nettype wire

// [hw/scrb_bank.sv]
// Volatile configuration register bank with apply triggers and active settings.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Trigger bit 0 rising applies large change
// - Mode bit set: fixed oscillator, control off
// - Mode bit clear: voltage control settings apply
// - VCO ratio is doubler times feedback divider
// - Output clock is VCO over output divider
// - Mode byte bit 7 disables the doubler
// - Trigger bit 1 rising applies small change
module scrb_bank
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Byte register port from the serial engine.
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// Active frequency plan.
	output logic doubler_en,
	output logic [scrb_pkg::SCRB_DIV_W:0] vco_mult,
	output logic [scrb_pkg::SCRB_DIV_W-1:0] out_div,
	output logic [scrb_pkg::SCRB_CP_W-1:0] charge_pump,
	// Active oscillator mode and voltage control.
	output logic fixed_osc_mode,
	output logic vc_input_en,
	output logic [1:0] vc_bandwidth,
	output logic [7:0] vc_gain,
	// Active crystal oscillator settings.
	output logic [1:0] overtone_amp_transconductance,
	output logic [5:0] load_trim_first_pin,
	output logic [3:0] amplifier_slice_count,
	output logic [2:0] load_trim_second_pin,
	output logic overtone_mode_disable,
	output logic [2:0] overtone_filter_resistance
);
	import scrb_pkg::*;

	// ----------------------------------------------------------------------
	// RAM register file
	// ----------------------------------------------------------------------

	logic [7:0] ram_ff [256];
	logic [7:0] nxt_ram [256];
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;

	// Writes to unmapped bytes are dropped so they keep reading zero.
	always_comb
	begin
		for (int i = 0; i < 256; i++)
			nxt_ram[i] = ram_ff[i];
		if (wr_en && scrb_is_mapped(wr_addr))
			nxt_ram[wr_addr] = wr_data;
		nxt_rd_data = rd_en ? ram_ff[rd_addr] : rd_data_ff;
		if (rd_en && !scrb_is_mapped(rd_addr))
			nxt_rd_data = SCRB_RD_UNMAPPED;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 256; i++)
				ram_ff[i] <= scrb_default(8'(i));
			rd_data_ff <= SCRB_RST_ZERO;
		end
		else
		begin
			for (int i = 0; i < 256; i++)
				ram_ff[i] <= nxt_ram[i];
			rd_data_ff <= nxt_rd_data;
		end
	end

	// ----------------------------------------------------------------------
	// Apply triggers
	// ----------------------------------------------------------------------

	logic [1:0] trig_level;
	logic [1:0] trig_rise;
	logic push_large;
	logic push_small;

	assign trig_level = {ram_ff[SCRB_APPLY_TRIG][SCRB_BIT_SMALL],
		ram_ff[SCRB_APPLY_TRIG][SCRB_BIT_LARGE]};

	// The trigger register is plain storage; only its edges act.
	scrb_rise_detect #(.W(2)) u_trig_edge
	(
		.clk(clk),
		.rst(rst),
		.level(trig_level),
		.rise(trig_rise)
	);

	assign push_large = trig_rise[0];
	assign push_small = trig_rise[1];

	// ----------------------------------------------------------------------
	// Active device settings
	// ----------------------------------------------------------------------

	logic [7:0] act_outdiv_ff, act_fbint_ff, act_ctrl_ff;
	logic [7:0] act_mode_ff, act_gain_ff, act_trim1_ff, act_amp_ff, act_ot_ff;
	logic [7:0] nxt_act_outdiv, nxt_act_fbint, nxt_act_ctrl;
	logic [7:0] nxt_act_mode, nxt_act_gain, nxt_act_trim1, nxt_act_amp, nxt_act_ot;

	// A large change also moves the frequency profile; a small one only the
	// miscellaneous bytes, so the PLL divider is never disturbed by it.
	always_comb
	begin
		nxt_act_outdiv = act_outdiv_ff;
		nxt_act_fbint = act_fbint_ff;
		nxt_act_ctrl = act_ctrl_ff;
		nxt_act_mode = act_mode_ff;
		nxt_act_gain = act_gain_ff;
		nxt_act_trim1 = act_trim1_ff;
		nxt_act_amp = act_amp_ff;
		nxt_act_ot = act_ot_ff;
		if (push_large || push_small)
		begin
			nxt_act_mode = ram_ff[SCRB_OSC_MODE];
			nxt_act_gain = ram_ff[SCRB_VC_GAIN];
			nxt_act_trim1 = ram_ff[SCRB_XO_TRIM1];
			nxt_act_amp = ram_ff[SCRB_XO_SLICE];
			nxt_act_ot = ram_ff[SCRB_XO_OT];
		end
		if (push_large)
		begin
			nxt_act_outdiv = ram_ff[SCRB_PROF_OUTDIV];
			nxt_act_fbint = ram_ff[SCRB_PROF_FBINT];
			nxt_act_ctrl = ram_ff[SCRB_PROF_CTRL];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			act_outdiv_ff <= SCRB_RST_OUTDIV;
			act_fbint_ff <= SCRB_RST_FBINT;
			act_ctrl_ff <= SCRB_RST_CTRL;
			act_mode_ff <= SCRB_RST_51;
			act_gain_ff <= SCRB_RST_52;
			act_trim1_ff <= SCRB_RST_55;
			act_amp_ff <= SCRB_RST_56;
			act_ot_ff <= SCRB_RST_57;
		end
		else
		begin
			act_outdiv_ff <= nxt_act_outdiv;
			act_fbint_ff <= nxt_act_fbint;
			act_ctrl_ff <= nxt_act_ctrl;
			act_mode_ff <= nxt_act_mode;
			act_gain_ff <= nxt_act_gain;
			act_trim1_ff <= nxt_act_trim1;
			act_amp_ff <= nxt_act_amp;
			act_ot_ff <= nxt_act_ot;
		end
	end

	// ----------------------------------------------------------------------
	// Decoded outputs
	// ----------------------------------------------------------------------

	logic [SCRB_DIV_W-1:0] fb_int;
	logic doubler_en_ff, nxt_doubler_en;
	logic [SCRB_DIV_W:0] vco_mult_ff, nxt_vco_mult;
	logic [SCRB_DIV_W-1:0] out_div_ff, nxt_out_div;
	logic [SCRB_CP_W-1:0] charge_pump_ff, nxt_charge_pump;
	logic fixed_ff, nxt_fixed, vc_en_ff, nxt_vc_en;
	logic [1:0] vc_bw_ff, nxt_vc_bw;
	logic [7:0] vc_gain_ff, nxt_vc_gain;
	logic [7:0] xo_a_ff, nxt_xo_a, xo_b_ff, nxt_xo_b, xo_c_ff, nxt_xo_c;

	assign fb_int = {act_ctrl_ff[SCRB_BIT_FBINT_MSB], act_fbint_ff};

	// Decode the active bytes. The fractional part of the feedback divider
	// stays in the profile bytes; only the integer ratio is given out.
	always_comb
	begin
		nxt_doubler_en = !act_mode_ff[SCRB_BIT_DBL_DIS];
		nxt_vco_mult = nxt_doubler_en ? {fb_int, 1'b0} : {1'b0, fb_int};
		nxt_out_div = {act_ctrl_ff[SCRB_BIT_OUTDIV_MSB], act_outdiv_ff};
		nxt_charge_pump = act_ctrl_ff[SCRB_CP_LSB +: SCRB_CP_W];
		nxt_fixed = act_mode_ff[SCRB_BIT_FIXED];
		nxt_vc_en = !nxt_fixed;
		nxt_vc_bw = nxt_fixed ? 2'b00 : act_mode_ff[1:0];
		nxt_vc_gain = nxt_fixed ? SCRB_RST_ZERO : act_gain_ff;
		nxt_xo_a = act_trim1_ff;
		nxt_xo_b = act_amp_ff;
		nxt_xo_c = act_ot_ff;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			doubler_en_ff <= 1'b0;
			vco_mult_ff <= '0;
			out_div_ff <= '0;
			charge_pump_ff <= '0;
			fixed_ff <= 1'b1;
			vc_en_ff <= 1'b0;
			vc_bw_ff <= 2'b00;
			vc_gain_ff <= SCRB_RST_ZERO;
			xo_a_ff <= SCRB_RST_ZERO;
			xo_b_ff <= SCRB_RST_ZERO;
			xo_c_ff <= SCRB_RST_ZERO;
		end
		else
		begin
			doubler_en_ff <= nxt_doubler_en;
			vco_mult_ff <= nxt_vco_mult;
			out_div_ff <= nxt_out_div;
			charge_pump_ff <= nxt_charge_pump;
			fixed_ff <= nxt_fixed;
			vc_en_ff <= nxt_vc_en;
			vc_bw_ff <= nxt_vc_bw;
			vc_gain_ff <= nxt_vc_gain;
			xo_a_ff <= nxt_xo_a;
			xo_b_ff <= nxt_xo_b;
			xo_c_ff <= nxt_xo_c;
		end
	end

	assign rd_data = rd_data_ff;
	assign doubler_en = doubler_en_ff;
	assign vco_mult = vco_mult_ff;
	assign out_div = out_div_ff;
	assign charge_pump = charge_pump_ff;
	assign fixed_osc_mode = fixed_ff;
	assign vc_input_en = vc_en_ff;
	assign vc_bandwidth = vc_bw_ff;
	assign vc_gain = vc_gain_ff;
	assign overtone_amp_transconductance = xo_a_ff[7:6];
	assign load_trim_first_pin = xo_a_ff[5:0];
	assign amplifier_slice_count = xo_b_ff[7:4];
	assign load_trim_second_pin = xo_b_ff[2:0];
	assign overtone_mode_disable = xo_c_ff[7];
	assign overtone_filter_resistance = xo_c_ff[6:4];

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------

	// Checks wake one edge after reset ends, so no attempt can start on the
	// release edge and compare reset-held outputs against decoded defaults.
	logic chk_arm_ff;
	logic nxt_chk_arm;

	always_comb
	begin
		nxt_chk_arm = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			chk_arm_ff <= 1'b0;
		else
			chk_arm_ff <= nxt_chk_arm;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !chk_arm_ff);

	// Write of bit 0 high onto a low trigger, then the edge is seen.
	sequence s_large_write;
		wr_en && wr_addr == SCRB_APPLY_TRIG && wr_data[SCRB_BIT_LARGE]
			&& !ram_ff[SCRB_APPLY_TRIG][SCRB_BIT_LARGE];
	endsequence

	sequence s_small_only;
		push_small && !push_large;
	endsequence

	a_large_push_copy: assert property (s_large_write ##1 1'b1 |=>
		act_fbint_ff == $past(ram_ff[SCRB_PROF_FBINT]) && act_outdiv_ff == $past(ram_ff[SCRB_PROF_OUTDIV]))
		else $error("large push did not copy the profile");

	a_fixed_mode_quiet: assert property (fixed_osc_mode |-> !vc_input_en && vc_gain == 8'h00
		&& vc_bandwidth == 2'b00)
		else $error("fixed mode left voltage control active");

	a_vc_mode_apply: assert property (!act_mode_ff[SCRB_BIT_FIXED] |=>
		vc_input_en && vc_gain == $past(act_gain_ff))
		else $error("voltage control settings not applied");

	a_vco_ratio: assert property (1'b1 |=> vco_mult ==
		($past(act_mode_ff[SCRB_BIT_DBL_DIS]) ? {1'b0, $past(fb_int)} : {$past(fb_int), 1'b0}))
		else $error("vco ratio wrong");

	a_out_div_track: assert property (1'b1 |=> out_div ==
		{$past(act_ctrl_ff[SCRB_BIT_OUTDIV_MSB]), $past(act_outdiv_ff)})
		else $error("output divider does not follow active profile");

	a_doubler_ctl: assert property ($changed(act_mode_ff[SCRB_BIT_DBL_DIS]) |=>
		doubler_en != $past(doubler_en))
		else $error("doubler control not followed");

	a_small_push_scope: assert property (s_small_only |=> act_ctrl_ff == $past(act_ctrl_ff)
		&& act_ot_ff == $past(ram_ff[SCRB_XO_OT]) && act_mode_ff == $past(ram_ff[SCRB_OSC_MODE]))
		else $error("small push scope wrong");

	a_single_trigger: assert property (trig_level[0] && $past(trig_level[0]) |-> !push_large
		##1 (!trig_level[0] || !push_large))
		else $error("held trigger fired again");

endmodule : scrb_bank

`default_nettype wire

// [test/scrb_host_model.sv]
// Host-side model that programs the config bank over its byte port.
`timescale 1ns/1ps
`default_nettype none

module scrb_host_model
(
	// Clock.
	input wire logic clk,
	// Byte register port towards the bank.
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	import scrb_pkg::*;

	// Idle port at time zero.
	initial
	begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
	end

	// ------------------------------------------------------------------
	// Byte transfers
	// ------------------------------------------------------------------
	// Released lines show the inverse so a stale value is never taken for a live one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask : wr

	// Read data is taken one cycle after the strobe edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		rd_addr <= ~a;
		#1;
		d = rd_data;
	endtask : rd

	// ------------------------------------------------------------------
	// Frequency plans
	// ------------------------------------------------------------------
	// A 160 MHz third-overtone crystal, fixed mode, VCO 8000 MHz, output 200 MHz.
	// The bandwidth bits are set on purpose, so fixed mode must be seen to hide them.
	task automatic program_overtone();
		wr(SCRB_OSC_MODE, 8'hC5);
		wr(SCRB_PROF_OUTDIV, 8'h28);
		wr(SCRB_PROF_FBINT, 8'h32);
		wr(SCRB_PROF_CTRL, 8'h04);
		wr(SCRB_XO_TRIM1, 8'hD5);
		wr(SCRB_XO_SLICE, 8'hC5);
		wr(SCRB_XO_OT, 8'h38);
	endtask : program_overtone

	// A 50 MHz fundamental crystal, doubled, VCO 7000 MHz, smallest output divider,
	// voltage control on with the 5 kHz bandwidth code.
	task automatic program_fundamental();
		wr(SCRB_OSC_MODE, 8'h42);
		wr(SCRB_PROF_OUTDIV, 8'h04);
		wr(SCRB_PROF_FBINT, 8'h46);
		wr(SCRB_PROF_CTRL, 8'h08);
		wr(SCRB_XO_TRIM1, 8'hBC);
		wr(SCRB_XO_SLICE, 8'h12);
		wr(SCRB_XO_OT, 8'h88);
	endtask : program_fundamental

endmodule : scrb_host_model
`default_nettype wire

// [test/scrb_bank_tb_top.sv]
// Self-checking testbench of the config register bank.
`timescale 1ns/1ps
`default_nettype none

module scrb_bank_tb_top;
	import scrb_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic clk;
	logic rst;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic doubler_en;
	logic [9:0] vco_mult;
	logic [8:0] out_div;
	logic [2:0] charge_pump;
	logic fixed_osc_mode;
	logic vc_input_en;
	logic [1:0] vc_bandwidth;
	logic [7:0] vc_gain;
	logic [1:0] amp_gm;
	logic [5:0] trim1;
	logic [3:0] slices;
	logic [2:0] trim2;
	logic fund_mode;
	logic [2:0] filter_res;
	logic [7:0] v;
	int errors = 0;
	int tests_run = 0;

	// ------------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------------
	scrb_host_model u_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
	scrb_bank u_dut (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.doubler_en(doubler_en), .vco_mult(vco_mult), .out_div(out_div),
		.charge_pump(charge_pump), .fixed_osc_mode(fixed_osc_mode),
		.vc_input_en(vc_input_en), .vc_bandwidth(vc_bandwidth), .vc_gain(vc_gain),
		.overtone_amp_transconductance(amp_gm), .load_trim_first_pin(trim1),
		.amplifier_slice_count(slices), .load_trim_second_pin(trim2),
		.overtone_mode_disable(fund_mode), .overtone_filter_resistance(filter_res));

	// ------------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Active outputs follow a push two edges after the write is taken, so four are allowed.
	task automatic check_plan(input logic d, input logic [9:0] m, input logic [8:0] o,
		input logic [2:0] c, input logic f, input logic [7:0] g, input logic [3:0] s,
		input logic [1:0] b);
		repeat (4) @(posedge clk);
		#1;
		check(16'(doubler_en), 16'(d));
		check(16'(vco_mult), 16'(m));
		check(16'(out_div), 16'(o));
		check(16'(charge_pump), 16'(c));
		check(16'(fixed_osc_mode), 16'(f));
		check(16'(vc_input_en), 16'(!f));
		check(16'(vc_gain), 16'(g));
		check(16'(vc_bandwidth), 16'(b));
		check(16'(slices), 16'(s));
	endtask : check_plan

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// A hang is cut short well above the length of the sequence.
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		check_plan(1'b0, 10'h046, 9'h038, 3'h4, 1'b0, 8'h2A, 4'h8, 2'h0);
		// Reserved bytes read back their defaults and keep what is written.
		for (int i = 0; i < SCRB_NRSVD; i++)
		begin
			u_host.rd(SCRB_RSVD_ADDR[i], v);
			check(16'(v), 16'(SCRB_RSVD_RST[i]));
		end
		u_host.wr(8'h63, 8'hA5);
		u_host.rd(8'h63, v);
		check(16'(v), 16'h00A5);
		u_host.wr(8'hA1, 8'hFF);
		u_host.rd(8'hA1, v);
		check(16'(v), 16'h0000);
		// RAM changes stay out of the active settings until a push.
		u_host.program_overtone();
		check_plan(1'b0, 10'h046, 9'h038, 3'h4, 1'b0, 8'h2A, 4'h8, 2'h0);
		u_host.wr(SCRB_APPLY_TRIG, 8'h01);
		check_plan(1'b0, 10'h032, 9'h028, 3'h2, 1'b1, 8'h00, 4'hC, 2'h0);
		check(16'(trim1), 16'h0015);
		check(16'(filter_res), 16'h0003);
		check(16'(amp_gm), 16'h0003);
		check(16'(trim2), 16'h0005);
		check(16'(fund_mode), 16'h0000);
		// Writing one over one is no new edge.
		u_host.program_fundamental();
		u_host.wr(SCRB_APPLY_TRIG, 8'h01);
		check_plan(1'b0, 10'h032, 9'h028, 3'h2, 1'b1, 8'h00, 4'hC, 2'h0);
		check(16'(trim1), 16'h0015);
		// Small push moves the oscillator bytes only.
		u_host.wr(SCRB_APPLY_TRIG, 8'h00);
		u_host.wr(SCRB_APPLY_TRIG, 8'h02);
		check_plan(1'b1, 10'h064, 9'h028, 3'h2, 1'b0, 8'h2A, 4'h1, 2'h2);
		check(16'(trim1), 16'h003C);
		check(16'(amp_gm), 16'h0002);
		check(16'(trim2), 16'h0002);
		check(16'(fund_mode), 16'h0001);
		check(16'(filter_res), 16'h0000);
		// Both bits together act as a large push.
		u_host.wr(SCRB_APPLY_TRIG, 8'h00);
		u_host.wr(SCRB_APPLY_TRIG, 8'h03);
		check_plan(1'b1, 10'h08C, 9'h004, 3'h4, 1'b0, 8'h2A, 4'h1, 2'h2);
		// A second reset brings back every default, RAM and active alike.
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		check_plan(1'b0, 10'h046, 9'h038, 3'h4, 1'b0, 8'h2A, 4'h8, 2'h0);
		u_host.rd(8'h63, v);
		check(16'(v), 16'h0000);
		give_verdict();
	end

endmodule : scrb_bank_tb_top
`default_nettype wire
